// ### src/gpw_pkg.sv
package gpw_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_6_4 = 8'hd4;
  localparam logic [7:0] IDX_PIN_6_5 = 8'hd5;
  localparam logic [7:0] IDX_PIN_6_6 = 8'hd6;
  localparam logic [7:0] IDX_PIN_6_7 = 8'hd7;
  localparam logic [7:0] IDX_COMB_TWO = 8'hef;
  localparam logic [7:0] IDX_COMB_ONE = 8'hf0;
  localparam logic [7:0] IDX_WDT_UNIT = 8'hf1;
  localparam logic [7:0] IDX_WATCHDOG_TIMEOUT_VALUE = 8'hf2;
  localparam logic [7:0] IDX_WATCHDOG_CONFIGURATION = 8'hf3;
  localparam logic [7:0] IDX_WDT_STATUS = 8'hf4;
  localparam logic [7:0] IDX_RING_SEL = 8'hf5;
  localparam logic [7:0] IDX_PIN_DATA = 8'hfa;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  // pin configuration fields
  localparam int PC_DIR = 0;
  localparam int PC_POL = 1;
  localparam int PC_FUNC_LO = 3;
  localparam int PC_GRP = 5;
  localparam int PC_OD = 7;
  localparam logic [7:0] PIN_CFG_RST = 8'h01;
  localparam logic [7:0] PIN_CFG_MASK = 8'hbb;
  localparam logic [1:0] FN_ROM = 2'h0;
  localparam logic [1:0] FN_IRQ = 2'h1;
  localparam logic [1:0] FN_GPIO = 2'h2;
  localparam logic [1:0] FN_ALT = 2'h3;
  // combined interrupt fields
  localparam int CI_FILT = 3;
  localparam int CI_ROUTE_LO = 4;
  localparam logic [7:0] CI_RST = 8'h00;
  localparam logic [7:0] CI_MASK = 8'hf8;
  localparam logic [3:0] CI_OFF = 4'h0;
  localparam logic [3:0] CI_INVALID = 4'h2;
  // watchdog, ring select and activate fields
  localparam int WU_SECONDS = 7;
  localparam logic [7:0] WU_MASK = 8'h80;
  localparam logic [7:0] WDT_RST = 8'h00;
  localparam int WATCHDOG_CONFIGURATION_KEEP = 1;
  localparam int RING_KBC_SEL = 7;
  localparam int ACT_BIT = 0;
  // irq numbers taken by each pin in its irq function
  localparam logic [3:0] PIN_IRQ_NUM [4] = '{4'h6, 4'h7, 4'h8, 4'ha};
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;
  localparam int MINUTE_S = 60;
endpackage

// ### src/gpw_pin_cell.sv
module gpw_pin_cell
  import gpw_pkg::*;
#(
  parameter bit HAS_ALT = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pad side
  input wire logic pad_in,
  // configuration and sources
  input wire logic [7:0] cfg,
  input wire logic gp_data,
  input wire logic rom_out,
  input wire logic rom_oe,
  input wire logic alt_out,
  // results
  output logic pad_out_next,
  output logic pad_oe_next,
  output logic level,
  output logic grp_req
);
  logic [2:0] sync_reg;
  logic level_reg;
  logic [1:0] func;
  logic drive;
  logic value;

  // three-stage capture of the pad
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], pad_in};
    end
  end

  // level moves once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else if (sync_reg[1] == sync_reg[2]) begin
      level_reg <= sync_reg[2];
    end
  end

  assign func = cfg[PC_FUNC_LO +: 2];
  assign level = level_reg ^ cfg[PC_POL];
  assign grp_req = level & cfg[PC_GRP];

  // function mux picks drive source
  always_comb begin
    drive = 1'b0;
    value = 1'b0;
    unique case (func)
      FN_ROM: begin
        drive = rom_oe;
        value = rom_out;
      end
      FN_IRQ: begin
        drive = 1'b0;
      end
      FN_GPIO: begin
        drive = ~cfg[PC_DIR];
        value = gp_data;
      end
      FN_ALT: begin
        drive = HAS_ALT & ~cfg[PC_DIR];
        value = alt_out;
      end
    endcase
  end

  always_comb begin
    pad_out_next = 1'b0;
    pad_oe_next = 1'b0;
    if (drive) begin
      if (cfg[PC_OD]) begin
        pad_oe_next = ~(value ^ cfg[PC_POL]);
      end else begin
        pad_out_next = value ^ cfg[PC_POL];
        pad_oe_next = 1'b1;
      end
    end
  end
endmodule

// ### src/gpw_top.sv
// What this block does
// - config bit 0 sets pin direction, one is input, zero is output.
// - config bit 1 inverts the pin value both ways when set.
// - pin 6.4 code 11 uses ring select bit 7 between two port pins.
// - pin 6.6 codes are rom data 6, irq8, gpio, reserved.
// - pin 6.7 codes are rom data 7, irq10, gpio, reserved.
// - config bit 5 adds the pin to the second combined interrupt.
// - config bit 7 picks open drain; bits 2 and 6 reserved.
// - pin config registers load 0x01 on battery power-on reset.
// - combined two bit 3 enables debounce; bits 2:0 read zero.
// - routing field 7:4 gives irq number, zero disables, 0010 invalid.
// - combined one register shares the combined two layout.
// - both combined registers load 0x00 on battery power-on reset.
// - group one feeds combined one; groups five and six feed combined two.
// - unit register bit 7 selects seconds, zero selects minutes.
// - unit and timeout registers clear on main reset or bus reset.
// - timeout value counts 1 to 255 units; zero disables.
// - watchdog does nothing while the logical device is not activated.
// - status bit goes one on timeout and reads zero while counting; here it stays one until a status write clears it.
// - config register clears fully on standby reset; bit 1 survives main reset.
//
// Chosen here: the APB interface to the registers.
module gpw_top
  import gpw_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES,
  parameter int DEBOUNCE_CYCLES = 16
) (
  // clock and main reset
  input wire logic pclk,
  input wire logic presetn,
  // power-on reset requests from other supplies
  input wire logic battery_por_req,
  input wire logic standby_por_req,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  // rom data bus function
  input wire logic [3:0] rom_data_out,
  input wire logic rom_data_oe,
  output logic [3:0] rom_data_in,
  // keyboard controller port pins
  input wire logic kbc_port1_bit7_out,
  input wire logic kbc_port1_bit2_out,
  output logic kbc_port1_bit7_in,
  output logic kbc_port1_bit2_in,
  // other group requests
  input wire logic group_one_req,
  input wire logic group_five_req,
  input wire logic group_six_low_req,
  // interrupt lines
  output logic [15:0] isa_irq,
  output logic combined_irq_one_line,
  output logic combined_irq_two_line,
  // watchdog
  output logic wdt_timeout,
  output logic wdt_timed_out
);
  localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int SCW = $clog2(SEC_CYCLES + 1);
  localparam logic [DBW-1:0] DB_LAST = DBW'(DEBOUNCE_CYCLES - 1);
  localparam logic [SCW-1:0] SC_LAST = SCW'(SEC_CYCLES - 1);
  localparam logic [5:0] MIN_LAST = 6'(MINUTE_S - 1);

  logic [7:0] pin_cfg_reg [4];
  logic [7:0] comb_reg [2];
  logic [7:0] wdt_unit_reg;
  logic [7:0] watchdog_timeout_value_reg;
  logic [7:0] watchdog_configuration_reg;
  logic watchdog_configuration_keep_reg;
  logic [7:0] ring_sel_reg;
  logic [3:0] gp_data_reg;
  logic active_reg;
  logic [2:0] rst_sync_reg [2];
  logic [1:0] rst_req_reg;
  logic [7:0] rd_next;
  logic [7:0] idx;
  logic hit;
  logic wr_en;
  logic rd_en;
  logic [3:0] pad_out_next;
  logic [3:0] pad_oe_next;
  logic [3:0] level;
  logic [3:0] grp_req;
  logic [3:0] alt_out;
  logic [1:0] comb_raw;
  logic [1:0] comb_filt_reg;
  logic [DBW-1:0] db_cnt_reg [2];
  logic [1:0] comb_out;
  logic [15:0] isa_irq_next;
  logic [SCW-1:0] sec_cnt_reg;
  logic [5:0] min_cnt_reg;
  logic sec_tick;
  logic unit_tick;
  logic [7:0] wdt_cnt_reg;
  logic expire;
  logic battery_rst;
  logic standby_rst;

  // apb decode: word aligned, index in bits 9:2
  assign idx = paddr[9:2];
  assign wr_en = psel & penable & pwrite & pready & hit; // refused addresses never write
  assign rd_en = psel & ~penable & ~pwrite;
  assign battery_rst = rst_req_reg[0];
  assign standby_rst = rst_req_reg[1];

  // address hit for mapped words
  always_comb begin
    hit = 1'b0;
    if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) begin
      unique case (idx)
        IDX_PIN_6_4, IDX_PIN_6_5, IDX_PIN_6_6, IDX_PIN_6_7: hit = 1'b1;
        IDX_COMB_TWO, IDX_COMB_ONE, IDX_WDT_UNIT, IDX_WATCHDOG_TIMEOUT_VALUE: hit = 1'b1;
        IDX_WATCHDOG_CONFIGURATION, IDX_WDT_STATUS, IDX_RING_SEL: hit = 1'b1;
        IDX_PIN_DATA, IDX_ACTIVATE: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // zero wait state answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable) begin
      prdata <= (rd_en && hit) ? {24'h0, rd_next} : 32'h0;
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    rd_next = 8'h0;
    unique case (idx)
      IDX_PIN_6_4: rd_next = pin_cfg_reg[0];
      IDX_PIN_6_5: rd_next = pin_cfg_reg[1];
      IDX_PIN_6_6: rd_next = pin_cfg_reg[2];
      IDX_PIN_6_7: rd_next = pin_cfg_reg[3];
      IDX_COMB_TWO: rd_next = comb_reg[1];
      IDX_COMB_ONE: rd_next = comb_reg[0];
      IDX_WDT_UNIT: rd_next = wdt_unit_reg;
      IDX_WATCHDOG_TIMEOUT_VALUE: rd_next = watchdog_timeout_value_reg;
      IDX_WATCHDOG_CONFIGURATION: rd_next = {watchdog_configuration_reg[7:2], watchdog_configuration_keep_reg, watchdog_configuration_reg[0]};
      IDX_WDT_STATUS: rd_next = {7'h0, wdt_timed_out};
      IDX_RING_SEL: rd_next = ring_sel_reg;
      IDX_PIN_DATA: rd_next = {level, 4'h0};
      IDX_ACTIVATE: rd_next = {7'h0, active_reg};
      default: rd_next = 8'h0;
    endcase
  end

  // capture of the battery and standby reset requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_reg[0] <= 3'h0;
      rst_sync_reg[1] <= 3'h0;
      rst_req_reg <= 2'h0;
    end else begin
      rst_sync_reg[0] <= {rst_sync_reg[0][1:0], battery_por_req};
      rst_sync_reg[1] <= {rst_sync_reg[1][1:0], standby_por_req};
      for (int i = 0; i < 2; i++) begin
        if (rst_sync_reg[i][1] == rst_sync_reg[i][2]) begin
          rst_req_reg[i] <= rst_sync_reg[i][2];
        end
      end
    end
  end

  // battery-backed pin and combined registers
  always_ff @(posedge pclk) begin
    if (battery_rst) begin
      for (int i = 0; i < 4; i++) begin
        pin_cfg_reg[i] <= PIN_CFG_RST;
      end
      comb_reg[0] <= CI_RST;
      comb_reg[1] <= CI_RST;
    end else if (wr_en) begin
      for (int i = 0; i < 4; i++) begin
        if (idx == IDX_PIN_6_4 + 8'(i)) begin
          pin_cfg_reg[i] <= pwdata[7:0] & PIN_CFG_MASK;
        end
      end
      if (idx == IDX_COMB_TWO) begin
        comb_reg[1] <= pwdata[7:0] & CI_MASK;
      end
      if (idx == IDX_COMB_ONE) begin
        comb_reg[0] <= pwdata[7:0] & CI_MASK;
      end
    end
  end

  // bit 1 cleared by standby reset only
  always_ff @(posedge pclk) begin
    if (standby_rst) begin
      watchdog_configuration_keep_reg <= 1'b0;
    end else if (wr_en && idx == IDX_WATCHDOG_CONFIGURATION) begin
      watchdog_configuration_keep_reg <= pwdata[WATCHDOG_CONFIGURATION_KEEP];
    end
  end

  // main-reset registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_unit_reg <= WDT_RST;
      watchdog_timeout_value_reg <= WDT_RST;
      watchdog_configuration_reg <= WDT_RST;
      ring_sel_reg <= 8'h0;
      gp_data_reg <= 4'h0;
      active_reg <= 1'b0;
    end else if (standby_rst) begin
      watchdog_configuration_reg <= WDT_RST;
    end else if (wr_en) begin
      unique case (idx)
        // only the unit bit is kept
        IDX_WDT_UNIT: wdt_unit_reg <= pwdata[7:0] & WU_MASK;
        IDX_WATCHDOG_TIMEOUT_VALUE: watchdog_timeout_value_reg <= pwdata[7:0];
        IDX_WATCHDOG_CONFIGURATION: watchdog_configuration_reg <= pwdata[7:0];
        IDX_RING_SEL: ring_sel_reg <= pwdata[7:0];
        IDX_PIN_DATA: gp_data_reg <= pwdata[7:4];
        IDX_ACTIVATE: active_reg <= pwdata[ACT_BIT];
        default: active_reg <= active_reg;
      endcase
    end
  end

  // ring select bit 7 picks the port pin
  assign alt_out[0] = ring_sel_reg[RING_KBC_SEL] ? kbc_port1_bit2_out : kbc_port1_bit7_out;
  assign alt_out[3:1] = 3'h7;

  // one cell per pin; only pin 6.4 owns the keyboard function
  for (genvar g = 0; g < 4; g++) begin : g_pin
    gpw_pin_cell #(
      .HAS_ALT(g == 0)
    ) u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .pad_in(pin_in[g]),
      .cfg(pin_cfg_reg[g]),
      .gp_data(gp_data_reg[g]),
      .rom_out(rom_data_out[g]),
      .rom_oe(rom_data_oe),
      .alt_out(alt_out[g]),
      .pad_out_next(pad_out_next[g]),
      .pad_oe_next(pad_oe_next[g]),
      .level(level[g]),
      .grp_req(grp_req[g])
    );
  end

  // pad and function outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
      rom_data_in <= 4'h0;
      kbc_port1_bit7_in <= 1'b1;
      kbc_port1_bit2_in <= 1'b1;
    end else begin
      pin_out <= pad_out_next;
      pin_oe <= pad_oe_next;
      rom_data_in <= level;
      // selected port pin sees the pad
      kbc_port1_bit7_in <= (pin_cfg_reg[0][PC_FUNC_LO +: 2] == FN_ALT &&
                            !ring_sel_reg[RING_KBC_SEL]) ? level[0] : 1'b1;
      kbc_port1_bit2_in <= (pin_cfg_reg[0][PC_FUNC_LO +: 2] == FN_ALT &&
                            ring_sel_reg[RING_KBC_SEL]) ? level[0] : 1'b1;
    end
  end

  // group sources of each combined request
  assign comb_raw[0] = group_one_req;
  assign comb_raw[1] = (|grp_req) | group_five_req | group_six_low_req;

  // debounce: follow the raw level after it has held steady
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comb_filt_reg <= 2'h0;
      db_cnt_reg[0] <= '0;
      db_cnt_reg[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (comb_raw[i] == comb_filt_reg[i]) begin
          db_cnt_reg[i] <= '0;
        end else if (db_cnt_reg[i] == DB_LAST) begin
          comb_filt_reg[i] <= comb_raw[i];
          db_cnt_reg[i] <= '0;
        end else begin
          db_cnt_reg[i] <= db_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  assign comb_out[0] = comb_reg[0][CI_FILT] ? comb_filt_reg[0] : comb_raw[0];
  assign comb_out[1] = comb_reg[1][CI_FILT] ? comb_filt_reg[1] : comb_raw[1];

  // irq line merge from pin functions and combined routing
  always_comb begin
    isa_irq_next = 16'h0;
    for (int i = 0; i < 4; i++) begin
      if (pin_cfg_reg[i][PC_FUNC_LO +: 2] == FN_IRQ) begin
        isa_irq_next[PIN_IRQ_NUM[i]] = isa_irq_next[PIN_IRQ_NUM[i]] | level[i];
      end
    end
    for (int k = 0; k < 2; k++) begin
      // routing code, off and invalid drive nothing
      if (comb_reg[k][CI_ROUTE_LO +: 4] != CI_OFF &&
          comb_reg[k][CI_ROUTE_LO +: 4] != CI_INVALID) begin
        isa_irq_next[comb_reg[k][CI_ROUTE_LO +: 4]] =
          isa_irq_next[comb_reg[k][CI_ROUTE_LO +: 4]] | comb_out[k];
      end
    end
  end

  // interrupt outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isa_irq <= 16'h0;
      combined_irq_one_line <= 1'b0;
      combined_irq_two_line <= 1'b0;
    end else begin
      isa_irq <= isa_irq_next;
      combined_irq_one_line <= comb_out[0];
      combined_irq_two_line <= comb_out[1];
    end
  end

  // prescaler held while not activated; restarted by value writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_reg <= '0;
      min_cnt_reg <= 6'h0;
    end else if (!active_reg || (wr_en && idx == IDX_WATCHDOG_TIMEOUT_VALUE)) begin
      sec_cnt_reg <= '0;
      min_cnt_reg <= 6'h0;
    end else if (sec_tick) begin
      sec_cnt_reg <= '0;
      min_cnt_reg <= (min_cnt_reg == MIN_LAST) ? 6'h0 : min_cnt_reg + 6'h1;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 1'b1;
    end
  end

  assign sec_tick = active_reg && sec_cnt_reg == SC_LAST;
  // unit is one second or sixty of them
  assign unit_tick = wdt_unit_reg[WU_SECONDS] ? sec_tick : (sec_tick && min_cnt_reg == MIN_LAST);
  // reaching zero raises the timeout event
  assign expire = unit_tick && wdt_cnt_reg == 8'h01;

  // countdown loaded by value write, zero stays idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt_reg <= 8'h0;
    end else if (wr_en && idx == IDX_WATCHDOG_TIMEOUT_VALUE) begin
      wdt_cnt_reg <= pwdata[7:0];
    end else if (unit_tick && wdt_cnt_reg != 8'h0) begin
      wdt_cnt_reg <= wdt_cnt_reg - 8'h01;
    end
  end

  // sticky status, timeout wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_timed_out <= 1'b0;
      wdt_timeout <= 1'b0;
    end else begin
      wdt_timeout <= expire;
      if (expire) begin
        wdt_timed_out <= 1'b1;
      end else if (wr_en && idx == IDX_WDT_STATUS) begin
        wdt_timed_out <= pwdata[0];
      end
    end
  end
endmodule

// ### bench/gpw_props.sv
module gpw_props
  import gpw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupts and watchdog
  input wire logic [15:0] isa_irq,
  input wire logic wdt_timeout,
  input wire logic wdt_timed_out
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bus answer timing, unused irq lines and timeout pulse
  chk_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_qual: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_irq_unused: assert property (isa_irq[0] == 1'b0 && isa_irq[2] == 1'b0)
    else $error("disabled or invalid irq line driven");
  chk_tmo_pulse: assert property (wdt_timeout |=> !wdt_timeout)
    else $error("timeout pulse too long");
  chk_tmo_status: assert property (wdt_timeout |-> ##[0:1] wdt_timed_out)
    else $error("status not set on timeout");
endmodule

bind gpw_top gpw_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .isa_irq(isa_irq),
  .wdt_timeout(wdt_timeout),
  .wdt_timed_out(wdt_timed_out)
);

// ### bench/gpw_board.sv
module gpw_board (
  // design pads
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  // board drivers
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  output logic [3:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // pad driver first, then board driver, else pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

// ### bench/tb_top.sv
module tb_top;
  import gpw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, bat_req, sby_req, psel, penable, pwrite, pready, pslverr, er;
  logic rom_oe, ko7, ko2, k7, k2, g1, g5, g6, c1, c2, wto, wtd, v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rs;
  logic [3:0] pin_in, pin_out, pin_oe, ext_en, ext_val, rom_out, rom_in;
  logic [15:0] isa_irq;
  logic [7:0] mdl [256];
  logic [7:0] ix;
  int bad_count, cmp_count, n, tos, hit;

  gpw_top #(.SEC_CYCLES(20), .DEBOUNCE_CYCLES(4)) dut (
    .pclk(pclk), .presetn(presetn), .battery_por_req(bat_req), .standby_por_req(sby_req),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .rom_data_out(rom_out), .rom_data_oe(rom_oe),
    .rom_data_in(rom_in), .kbc_port1_bit7_out(ko7), .kbc_port1_bit2_out(ko2),
    .kbc_port1_bit7_in(k7), .kbc_port1_bit2_in(k2), .group_one_req(g1),
    .group_five_req(g5), .group_six_low_req(g6), .isa_irq(isa_irq),
    .combined_irq_one_line(c1), .combined_irq_two_line(c2), .wdt_timeout(wto),
    .wdt_timed_out(wtd));
  gpw_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // clock and timeout pulse count
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (wto === 1'b1) tos++;
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic w(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] msk(input logic [7:0] i);
    if (i >= 8'hd4 && i <= 8'hd7) return 8'hbb;
    if (i == 8'hef || i == 8'hf0) return 8'hf8;
    if (i == 8'hf1) return 8'h80;
    return 8'hff;
  endfunction
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'h0, i, 2'h0}, d);
    mdl[i] = d & msk(i);
  endtask
  task automatic rdc(input logic [7:0] i);
    apb(1'b0, {2'h0, i, 2'h0}, 8'h0);
    chk(rd, {24'h0, mdl[i]});
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  initial begin
    #800000;
    bad_count++;
    complete_run();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rom_oe, ko7, ko2, g1, g5, g6} = '0;
    {bat_req, sby_req, ext_en, ext_val, rom_out, bad_count, cmp_count, tos} = '0;
    bat_req = 1'b1;
    sby_req = 1'b1;
    ext_en = 4'hf;
    rs = 32'd17157;
    for (int i = 0; i < 256; i++) mdl[i] = (i >= 8'hd4 && i <= 8'hd7) ? 8'h01 : 8'h00;
    w(12);
    presetn <= 1'b1;
    w(6);
    bat_req <= 1'b0;
    sby_req <= 1'b0;
    w(6);
    // reset values, then random writes with reserved bits masked
    for (int i = 0; i < 18; i++) begin
      ix = (i % 9 < 4) ? 8'hd4 + i % 9 : 8'heb + i % 9;
      rs = xs(rs);
      if (i >= 9) wr(ix, rs[7:0]);
      rdc(ix);
      if (i >= 9) wr(ix, (ix < 8'he0) ? 8'h01 : 8'h00);
    end
    // unmapped and misaligned accesses refused
    apb(1'b0, 12'h3fc, 8'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h351, 8'hff);
    chk(er, 1'b1);
    rdc(8'hd4);
    // output drive, polarity and open drain on pin 6.6
    ext_en <= 4'h0;
    for (int i = 0; i < 8; i++) begin
      wr(8'hd6, {i[2], 4'h2, 1'b0, i[1], 1'b0});
      wr(8'hfa, {1'b0, i[0], 6'h0});
      w(8);
      v = i[0] ^ i[1];
      chk(pin_oe[2], i[2] ? !v : 1'b1);
      chk(pin_out[2], v & !i[2]);
    end
    wr(8'hd6, 8'h11);
    wr(8'hd7, 8'h18);
    w(8);
    chk(pin_oe[3:2], 2'h0);
    wr(8'hd6, 8'h18);
    w(8);
    chk(pin_oe[2], 1'b0);
    ext_en <= 4'hf;
    // irq function and rom data levels per pin
    for (int k = 0; k < 8; k++) begin
      wr(8'hd4 + k / 2, {6'h02, k[0], 1'b1});
      for (int j = 0; j < 2; j++) begin
        ext_val[k / 2] <= j[0];
        w(10);
        chk(isa_irq[PIN_IRQ_NUM[k / 2]], j[0] ^ k[0]);
        chk(rom_in[k / 2], j[0] ^ k[0]);
      end
      wr(8'hd4 + k / 2, 8'h01);
      ext_val <= 4'h0;
    end
    wr(8'hef, 8'h20);
    g5 <= 1'b1;
    w(6);
    chk(isa_irq, 16'h0);
    wr(8'hef, 8'h50);
    w(6);
    chk({c2, isa_irq}, {1'b1, 16'h0020});
    g5 <= 1'b0;
    g6 <= 1'b1;
    w(6);
    chk(isa_irq[5], 1'b1);
    g6 <= 1'b0;
    wr(8'hd5, 8'h31);
    ext_val[1] <= 1'b1;
    w(10);
    chk(isa_irq[5], 1'b1);
    wr(8'hd5, 8'h11);
    w(6);
    chk(isa_irq[5], 1'b0);
    // debounce drops a short pulse, passes a steady level
    wr(8'hef, 8'h58);
    wr(8'hd5, 8'h31);
    ext_val[1] <= 1'b0;
    w(12);
    hit = 0;
    ext_val[1] <= 1'b1;
    w(2);
    ext_val[1] <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      w(1);
      if (isa_irq[5] !== 1'b0) hit++;
    end
    chk(hit, 0);
    ext_val[1] <= 1'b1;
    w(14);
    chk(isa_irq[5], 1'b1);
    wr(8'hef, 8'h00);
    wr(8'hd5, 8'h01);
    // first combined interrupt from group one
    wr(8'hf0, 8'h30);
    g1 <= 1'b1;
    w(6);
    chk({c1, isa_irq[3]}, 2'h3);
    g1 <= 1'b0;
    wr(8'hf0, 8'h00);
    // keyboard port pin select on pin 6.4
    wr(8'hd4, 8'h19);
    ext_val[0] <= 1'b0;
    w(10);
    chk({k7, k2}, 2'h1);
    wr(8'hf5, 8'h80);
    w(4);
    chk({k7, k2}, 2'h2);
    // port pin value drives the pad when code 11 is an output
    wr(8'hd4, 8'h18);
    ko2 <= 1'b1;
    w(8);
    chk({pin_oe[0], pin_out[0]}, 2'h3);
    ko2 <= 1'b0;
    w(4);
    chk({pin_oe[0], pin_out[0]}, 2'h2);
    wr(8'h30, 8'h01);
    wr(8'hf1, 8'h80);
    wr(8'hf2, 8'h02);
    n = 0;
    while (wto !== 1'b1 && n < 200) begin
      w(1);
      n++;
    end
    chk(n >= 36 && n <= 46, 1'b1);
    mdl[8'hf4] = 8'h01;
    rdc(8'hf4);
    wr(8'hf2, 8'h00);
    n = tos;
    w(100);
    chk(tos, n);
    // minutes unit: one unit is sixty second ticks
    wr(8'hf1, 8'h00);
    wr(8'hf2, 8'h01);
    n = 0;
    while (wto !== 1'b1 && n < 1400) begin
      w(1);
      n++;
    end
    chk(n >= 1190 && n <= 1210, 1'b1);
    // main reset keeps cfg bit 1 only, standby clears it
    wr(8'hf3, 8'h02);
    wr(8'hf1, 8'h80);
    presetn <= 1'b0;
    w(3);
    presetn <= 1'b1;
    w(3);
    mdl[8'hf1] = 8'h00;
    mdl[8'hf2] = 8'h00;
    rdc(8'hf1);
    rdc(8'hf2);
    rdc(8'hf3);
    sby_req <= 1'b1;
    w(8);
    sby_req <= 1'b0;
    w(6);
    mdl[8'hf3] = 8'h00;
    rdc(8'hf3);
    complete_run();
  end
endmodule
